// File: common/lsr_defs.svh
`ifndef LSR_DEFS_SVH
`define LSR_DEFS_SVH
// Overview of operation
// - subclass 1 sysref capture sets status bit 16
// - status bit 0 shows link sync, resets 0
// - debug word holds eight 4-bit lane nibbles
// - nibble bit 3 flags start of data
// - nibble bit 2 flags start of alignment sequence
// - nibble bit 1 shows code group sync
// - nibble bit 0 shows K28.5 reception now
// - bits 3:2 sticky, cleared by read or reset
// - bits 1:0 follow live lane state
// - writable 5-bit lane_identifier, resets to index
// - receive side stores captured alignment parameters
// - transmit version, F and K come from configuration
// - octets per frame in bits 7:0
// - frames per multiframe in bits 4:0
// - lanes and lane_identifier receive only
// - transmit fields written by software, bank/device
// - sample format fields, reset zero
// - frame layout fields, reset zero
// - scrambling flag captured, transmit shows configuration
// - checksum receive only, reserved fields writable
// - transmit checksum computed per lane by hardware

`define LSR_LANES 8
`define LSR_IDX_SYNC 4'h0
`define LSR_IDX_DEBUG 4'h1
`define LSR_IDX_LANE_IDENTIFIER 4'h2
`define LSR_IDX_CFG0 4'h3
`define LSR_IDX_CFG1 4'h4
`define LSR_IDX_CFG2 4'h5
`define LSR_IDX_CFG3 4'h6
`define LSR_IDX_CFG4 4'h7
`define LSR_IDX_CFG5 4'h8
`define LSR_IDX_CFG6 4'h9

`define LSR_SYNC_BIT 0
`define LSR_SYSREF_BIT 16
`define LSR_SYNC_MASK 32'h0001_0001
`define LSR_DBG_W 4
`define LSR_DBG_SOD 3
`define LSR_DBG_SOILA 2
`define LSR_DBG_CGS 1
`define LSR_DBG_K28 0
`define LSR_LID_W 5
`define LSR_ZERO 32'h0000_0000

`define LSR_VER_LSB 8
`define LSR_SUB_LSB 0
`define LSR_F_LSB 0
`define LSR_K_LSB 0
`define LSR_L_LSB 24
`define LSR_LID_LSB 16
`define LSR_BID_LSB 8
`define LSR_DID_LSB 0
`define LSR_CS_LSB 24
`define LSR_NP_LSB 16
`define LSR_N_LSB 8
`define LSR_M_LSB 0
`define LSR_CF_LSB 24
`define LSR_HD_LSB 16
`define LSR_S_LSB 8
`define LSR_SCR_LSB 0
`define LSR_FCHK_LSB 16
`define LSR_RES2_LSB 8
`define LSR_RES1_LSB 0
`endif

// File: common/lsr_pkg.sv
package lsr_pkg;
  typedef struct packed {
    logic [2:0] version;
    logic [2:0] subclass;
    logic [7:0] f;
    logic [4:0] k;
    logic [4:0] l;
    logic [4:0] lid;
    logic [3:0] bid;
    logic [7:0] did;
    logic [1:0] cs;
    logic [4:0] np;
    logic [4:0] n;
    logic [7:0] m;
    logic [4:0] cf;
    logic hd;
    logic [4:0] s;
    logic scr;
    logic [7:0] fchk;
    logic [7:0] res2;
    logic [7:0] res1;
  } lsr_ila_t;

  typedef struct packed {
    logic [3:0] idx;
    logic [2:0] lane;
    logic wr;
    logic rd;
    logic [31:0] wdata;
  } lsr_req_t;

  typedef struct packed {
    logic sod;
    logic soila;
    logic cgs;
    logic k28;
  } lsr_lane_ev_t;
endpackage

// File: tb/link_status_and_ila_config_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module link_status_and_ila_config_regs_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic mode_tx = 1'b0;
  logic subclass_one = 1'b0;
  lsr_pkg::lsr_req_t req = '0;
  lsr_pkg::lsr_ila_t tx_cfg = '0;
  lsr_pkg::lsr_ila_t m_sw;
  lsr_pkg::lsr_ila_t m_rx [8];
  lsr_pkg::lsr_lane_ev_t [7:0] lane_ev;
  lsr_pkg::lsr_ila_t [7:0] ila_rx, tx_ila;
  logic [7:0] ila_rx_valid, m_sod, m_soi;
  logic [7:0] m_cgs = 8'h00;
  logic [7:0] m_k28 = 8'h00;
  logic [4:0] m_lid [8];
  logic [31:0] rdata;
  logic rvalid, link_sync, sysref_evt, m_sref;
  logic m_sync = 1'b0;
  int fail_count = 0;
  int tests_run = 0;
  int seed = 37489;
  always #12.5 clk = ~clk;
  lsr_regs uut (.clk(clk), .rst(rst), .ce(ce), .req(req), .rdata(rdata),
    .rvalid(rvalid), .mode_tx(mode_tx), .subclass_one(subclass_one),
    .sysref_evt(sysref_evt), .link_sync(link_sync), .lane_ev(lane_ev),
    .ila_rx_valid(ila_rx_valid), .ila_rx(ila_rx), .tx_cfg(tx_cfg),
    .tx_ila(tx_ila));
  lsr_lane_model far (.clk(clk), .lane_ev(lane_ev),
    .ila_rx_valid(ila_rx_valid), .ila_rx(ila_rx), .link_sync(link_sync),
    .sysref_evt(sysref_evt));
  function automatic lsr_pkg::lsr_ila_t txe(int ln);
    lsr_pkg::lsr_ila_t t;
    t = m_sw;
    t.version = tx_cfg.version;
    t.subclass = tx_cfg.subclass;
    t.f = tx_cfg.f;
    t.k = tx_cfg.k;
    t.l = tx_cfg.l;
    t.scr = tx_cfg.scr;
    t.lid = m_lid[ln];
    t.fchk = t.version + t.subclass + t.f + t.k + t.l + t.lid + t.bid + t.did
      + t.cs + t.np + t.n + t.m + t.cf + t.hd + t.s + t.scr + t.res2
      + t.res1;
    return t;
  endfunction
  function automatic logic [31:0] pk(lsr_pkg::lsr_ila_t p, int idx);
    case (idx)
      3: return {21'h0, p.version, 5'h0, p.subclass};
      4: return {24'h0, p.f};
      5: return {27'h0, p.k};
      6: return {3'h0, p.l, 3'h0, p.lid, 4'h0, p.bid, p.did};
      7: return {6'h0, p.cs, 3'h0, p.np, 3'h0, p.n, p.m};
      8: return {3'h0, p.cf, 7'h0, p.hd, 3'h0, p.s, 7'h0, p.scr};
      9: return {8'h0, p.fchk, p.res2, p.res1};
      default: return 32'h0;
    endcase
  endfunction
  function automatic logic [31:0] ex(int idx, int ln);
    logic [31:0] w;
    int i;
    w = 32'h0;
    if (idx == 0) w = {15'h0, m_sref, 15'h0, m_sync};
    if (idx == 1)
      for (i = 0; i < 8; i++)
        w[4*i +: 4] = {m_sod[i], m_soi[i], m_cgs[i], m_k28[i]};
    if (idx == 2) w = {27'h0, m_lid[ln]};
    if (idx > 2 && idx < 10 && !mode_tx) w = pk(m_rx[ln], idx);
    if (idx > 5 && idx < 10 && mode_tx) w = pk(txe(ln), idx);
    return w;
  endfunction
  task automatic cmp(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_ila(input int ln, input lsr_pkg::lsr_ila_t e);
    tests_run++;
    if (tx_ila[ln] !== e) begin
      fail_count++;
      $display("unexpected tx_ila %0d expected %h seen %h", ln, e, tx_ila[ln]);
    end
  endtask
  task automatic rd(input logic [3:0] idx, input logic [2:0] ln);
    logic [31:0] e;
    e = ex(idx, ln);
    req.idx <= idx;
    req.lane <= ln;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    if (idx == 4'h1) begin
      m_sod = 8'h00;
      m_soi = 8'h00;
    end
    #1;
    cmp("rvalid", 32'h1, {31'h0, rvalid});
    cmp("rdata", e, rdata);
    @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] idx, input logic [2:0] ln,
    input logic [31:0] d);
    req.idx <= idx;
    req.lane <= ln;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
    req.wdata <= ~d;
    if (ce && idx == 4'h2) m_lid[ln] = d[4:0];
    if (ce && mode_tx && idx == 4'h6) {m_sw.bid, m_sw.did} = d[11:0];
    if (ce && mode_tx && idx == 4'h7) begin
      {m_sw.cs, m_sw.np} = {d[25:24], d[20:16]};
      {m_sw.n, m_sw.m} = {d[12:8], d[7:0]};
    end
    if (ce && mode_tx && idx == 4'h8) begin
      {m_sw.cf, m_sw.hd, m_sw.s} = {d[28:24], d[16], d[12:8]};
    end
    if (ce && mode_tx && idx == 4'h9) {m_sw.res2, m_sw.res1} = d[15:0];
    @(posedge clk);
  endtask
  task automatic do_reset();
    int i;
    rst <= 1'b1;
    repeat (10) @(posedge clk);
    m_sw = '0;
    m_sref = 1'b0;
    m_sod = 8'h00;
    m_soi = 8'h00;
    for (i = 0; i < 8; i++) begin
      m_lid[i] = 5'(i);
      m_rx[i] = '0;
    end
    rst <= 1'b0;
    @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #(5000 * 25);
    fail_count++;
    give_verdict();
  end
  initial begin
    int i, j;
    logic [127:0] r;
    lsr_pkg::lsr_lane_ev_t [7:0] v;
    do_reset();
    // index 15 is unmapped and must read zero
    for (i = 0; i < 16; i++)
      for (j = 0; j < 8; j++)
        rd(4'(i), 3'(j));
    $display("test defaults done");
    far.sync(1'b1);
    m_sync = 1'b1;
    far.sref();
    @(posedge clk);
    rd(4'h0, 3'h0);
    subclass_one <= 1'b1;
    far.sref();
    m_sref = 1'b1;
    @(posedge clk);
    rd(4'h0, 3'h0);
    $display("test sync done");
    for (i = 0; i < 6; i++) begin
      v = (i < 4) ? $random(seed) : '0;
      for (j = 0; j < 8; j++) {m_cgs[j], m_k28[j]} = {v[j].cgs, v[j].k28};
      fork
        far.ev(v);
        rd(4'h1, 3'h0);
      join
      for (j = 0; j < 8; j++) begin
        m_sod[j] = m_sod[j] | v[j].sod;
        m_soi[j] = m_soi[j] | v[j].soila;
      end
    end
    $display("test debug done");
    // ids 8 to 15, as on the second core of a wide link; junk above bit 4
    for (j = 0; j < 8; j++) begin
      r[31:0] = ($random(seed) & 32'hffff_ffe0) | (j + 8);
      wr(4'h2, 3'(j), r[31:0]);
    end
    ce <= 1'b0;
    wr(4'h2, 3'h3, 32'h0000_0015);
    ce <= 1'b1;
    for (j = 0; j < 8; j++) rd(4'h2, 3'(j));
    $display("test lane_identifier done");
    for (j = 0; j < 8; j++) begin
      r = {$random(seed), $random(seed), $random(seed), $random(seed)};
      far.ila(j, r[96:0]);
      m_rx[j] = r[96:0];
      wr(4'h6, 3'(j), 32'hffff_ffff);
    end
    for (i = 3; i < 10; i++)
      for (j = 0; j < 8; j++)
        rd(4'(i), 3'(j));
    $display("test receive done");
    r = {$random(seed), $random(seed), $random(seed), $random(seed)};
    mode_tx <= 1'b1;
    tx_cfg <= r[96:0];
    for (i = 6; i < 10; i++) wr(4'(i), 3'($random(seed)), $random(seed));
    far.ila(6, r[96:0]);
    repeat (2) @(posedge clk);
    #1;
    for (j = 0; j < 8; j++) cmp_ila(j, txe(j));
    @(posedge clk);
    for (i = 3; i < 10; i++)
      for (j = 0; j < 8; j++)
        rd(4'(i), 3'(j));
    $display("test transmit done");
    mode_tx <= 1'b0;
    do_reset();
    rd(4'h0, 3'h0);
    rd(4'h2, 3'h5);
    $display("test second reset done");
    give_verdict();
  end
endmodule
`default_nettype wire

// File: tb/lsr_lane_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsr_lane_model (
  input wire logic clk, // management clock
  output lsr_pkg::lsr_lane_ev_t [7:0] lane_ev, // per-lane status
  output logic [7:0] ila_rx_valid, // capture strobes
  output lsr_pkg::lsr_ila_t [7:0] ila_rx, // captured parameters
  output logic link_sync, // link synchronised level
  output logic sysref_evt // sysref captured pulse
);
  initial begin
    lane_ev = '0;
    ila_rx_valid = 8'h00;
    ila_rx = '0;
    link_sync = 1'b0;
    sysref_evt = 1'b0;
  end
  // start pulses last one cycle, sync levels stay until changed
  task automatic ev(input lsr_pkg::lsr_lane_ev_t [7:0] v);
    int i;
    lane_ev <= v;
    @(posedge clk);
    for (i = 0; i < 8; i++) begin
      v[i].sod = 1'b0;
      v[i].soila = 1'b0;
    end
    lane_ev <= v;
  endtask
  // parameters are only meaningful in the strobe cycle, so scramble after
  task automatic ila(input int ln, input lsr_pkg::lsr_ila_t p);
    ila_rx[ln] <= p;
    ila_rx_valid <= 8'h01 << ln;
    @(posedge clk);
    ila_rx_valid <= 8'h00;
    ila_rx[ln] <= ~p;
  endtask
  task automatic sync(input logic b);
    link_sync <= b;
  endtask
  task automatic sref();
    sysref_evt <= 1'b1;
    @(posedge clk);
    sysref_evt <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: verilog/lsr_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "lsr_defs.svh"

module lsr_regs (
  input wire logic clk, // 40 MHz management clock
  input wire logic rst, // async core reset, active high
  input wire logic ce, // clock enable, freezes all state
  input wire lsr_pkg::lsr_req_t req, // register access request
  output logic [31:0] rdata, // read data, registered
  output logic rvalid, // read data valid pulse
  input wire logic mode_tx, // 1 = transmit configuration
  input wire logic subclass_one, // subclass 1 operation
  input wire logic sysref_evt, // sysref captured pulse
  input wire logic link_sync, // link synchronisation level
  input wire lsr_pkg::lsr_lane_ev_t [7:0] lane_ev, // per-lane status
  input wire logic [7:0] ila_rx_valid, // captured sequence strobe
  input wire lsr_pkg::lsr_ila_t [7:0] ila_rx, // captured parameters
  input wire lsr_pkg::lsr_ila_t tx_cfg, // core transmit configuration
  output lsr_pkg::lsr_ila_t [7:0] tx_ila // per-lane values to send
);

  logic sync_q;
  logic sysref_q;
  logic [7:0] sod_q;
  logic [7:0] soila_q;
  logic [`LSR_LID_W-1:0] lane_identifier_q [`LSR_LANES];
  lsr_pkg::lsr_ila_t rx_q [`LSR_LANES];
  lsr_pkg::lsr_ila_t tx_sw_q;
  lsr_pkg::lsr_ila_t tx_sw_d;
  lsr_pkg::lsr_ila_t tx_ila_d [`LSR_LANES];
  lsr_pkg::lsr_ila_t tx_ila_q [`LSR_LANES];
  logic [31:0] rdata_q;
  logic rvalid_q;

  // checksum over all parameter fields except fchk, modulo 256
  function automatic logic [7:0] ila_sum(input lsr_pkg::lsr_ila_t p);
    logic [7:0] s;
    s = 8'(p.version) + 8'(p.subclass) + p.f + 8'(p.k);
    s = s + 8'(p.l) + 8'(p.lid) + 8'(p.bid) + p.did;
    s = s + 8'(p.cs) + 8'(p.np) + 8'(p.n) + p.m;
    s = s + 8'(p.cf) + 8'(p.hd) + 8'(p.s) + 8'(p.scr);
    s = s + p.res2 + p.res1;
    return s;
  endfunction

  // places the fields of one parameter register into a word
  function automatic logic [31:0] pack_cfg(input logic [3:0] idx,
      input lsr_pkg::lsr_ila_t p);
    logic [31:0] w;
    w = `LSR_ZERO;
    case (idx)
      `LSR_IDX_CFG0: begin
        w[`LSR_VER_LSB +: $bits(p.version)] = p.version;
        w[`LSR_SUB_LSB +: $bits(p.subclass)] = p.subclass;
      end
      `LSR_IDX_CFG1: begin
        w[`LSR_F_LSB +: $bits(p.f)] = p.f;
      end
      `LSR_IDX_CFG2: begin
        w[`LSR_K_LSB +: $bits(p.k)] = p.k;
      end
      `LSR_IDX_CFG3: begin
        w[`LSR_L_LSB +: $bits(p.l)] = p.l;
        w[`LSR_LID_LSB +: $bits(p.lid)] = p.lid;
        w[`LSR_BID_LSB +: $bits(p.bid)] = p.bid;
        w[`LSR_DID_LSB +: $bits(p.did)] = p.did;
      end
      `LSR_IDX_CFG4: begin
        w[`LSR_CS_LSB +: $bits(p.cs)] = p.cs;
        w[`LSR_NP_LSB +: $bits(p.np)] = p.np;
        w[`LSR_N_LSB +: $bits(p.n)] = p.n;
        w[`LSR_M_LSB +: $bits(p.m)] = p.m;
      end
      `LSR_IDX_CFG5: begin
        w[`LSR_CF_LSB +: $bits(p.cf)] = p.cf;
        w[`LSR_HD_LSB] = p.hd;
        w[`LSR_S_LSB +: $bits(p.s)] = p.s;
        w[`LSR_SCR_LSB] = p.scr;
      end
      `LSR_IDX_CFG6: begin
        w[`LSR_FCHK_LSB +: $bits(p.fchk)] = p.fchk;
        w[`LSR_RES2_LSB +: $bits(p.res2)] = p.res2;
        w[`LSR_RES1_LSB +: $bits(p.res1)] = p.res1;
      end
      default: begin
        w = `LSR_ZERO;
      end
    endcase
    return w;
  endfunction

  wire rd_go = ce & req.rd;
  wire wr_go = ce & req.wr;
  wire sel_sync = (req.idx == `LSR_IDX_SYNC);
  wire sel_dbg = (req.idx == `LSR_IDX_DEBUG);
  wire sel_lid = (req.idx == `LSR_IDX_LANE_IDENTIFIER);
  wire sel_hw_cfg = (req.idx == `LSR_IDX_CFG0) ||
      (req.idx == `LSR_IDX_CFG1) || (req.idx == `LSR_IDX_CFG2);
  wire dbg_clr = rd_go & sel_dbg;
  wire sw_wr = wr_go & mode_tx;
  wire [31:0] wd = req.wdata;

  // receive-side view, or the transmit values of the addressed lane
  wire lsr_pkg::lsr_ila_t lane_view = mode_tx ? tx_ila_q[req.lane] :
      rx_q[req.lane];

  // transmit registers 3 to 5 hold only generated fields and are not applicable
  wire hide_cfg = mode_tx & sel_hw_cfg;

  wire [31:0] sync_word = {15'h0000, sysref_q, 15'h0000, sync_q};

  logic [31:0] dbg_word;
  always_comb begin
    dbg_word = `LSR_ZERO;
    for (int i = 0; i < `LSR_LANES; i++) begin
      dbg_word[i*`LSR_DBG_W + `LSR_DBG_SOD] = sod_q[i];
      dbg_word[i*`LSR_DBG_W + `LSR_DBG_SOILA] = soila_q[i];
      dbg_word[i*`LSR_DBG_W + `LSR_DBG_CGS] = lane_ev[i].cgs;
      dbg_word[i*`LSR_DBG_W + `LSR_DBG_K28] = lane_ev[i].k28;
    end
  end

  logic [31:0] rd_word;
  always_comb begin
    if (sel_sync) begin
      rd_word = sync_word;
    end else if (sel_dbg) begin
      rd_word = dbg_word;
    end else if (sel_lid) begin
      rd_word = {27'h0000000, lane_identifier_q[req.lane]};
    end else if (hide_cfg) begin
      rd_word = `LSR_ZERO;
    end else begin
      rd_word = pack_cfg(req.idx, lane_view);
    end
  end

  // software-set transmit fields; generated ones are never stored
  always_comb begin
    tx_sw_d = tx_sw_q;
    if (sw_wr && req.idx == `LSR_IDX_CFG3) begin
      tx_sw_d.bid = wd[`LSR_BID_LSB +: $bits(tx_sw_d.bid)];
      tx_sw_d.did = wd[`LSR_DID_LSB +: $bits(tx_sw_d.did)];
    end else if (sw_wr && req.idx == `LSR_IDX_CFG4) begin
      tx_sw_d.cs = wd[`LSR_CS_LSB +: $bits(tx_sw_d.cs)];
      tx_sw_d.np = wd[`LSR_NP_LSB +: $bits(tx_sw_d.np)];
      tx_sw_d.n = wd[`LSR_N_LSB +: $bits(tx_sw_d.n)];
      tx_sw_d.m = wd[`LSR_M_LSB +: $bits(tx_sw_d.m)];
    end else if (sw_wr && req.idx == `LSR_IDX_CFG5) begin
      tx_sw_d.cf = wd[`LSR_CF_LSB +: $bits(tx_sw_d.cf)];
      tx_sw_d.hd = wd[`LSR_HD_LSB];
      tx_sw_d.s = wd[`LSR_S_LSB +: $bits(tx_sw_d.s)];
    end else if (sw_wr && req.idx == `LSR_IDX_CFG6) begin
      tx_sw_d.res2 = wd[`LSR_RES2_LSB +: $bits(tx_sw_d.res2)];
      tx_sw_d.res1 = wd[`LSR_RES1_LSB +: $bits(tx_sw_d.res1)];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_q <= 1'b0;
      sysref_q <= 1'b0;
    end else if (ce) begin
      sync_q <= link_sync;
      sysref_q <= sysref_q | (subclass_one & sysref_evt);
    end
  end

  // sticky flags: a new event outranks the clearing read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sod_q <= 8'h00;
      soila_q <= 8'h00;
    end else if (ce) begin
      for (int i = 0; i < `LSR_LANES; i++) begin
        sod_q[i] <= (sod_q[i] & ~dbg_clr) | lane_ev[i].sod;
        soila_q[i] <= (soila_q[i] & ~dbg_clr) | lane_ev[i].soila;
      end
    end
  end
  // carried by the two assignments above

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_sw_q <= '0;
    end else if (ce) begin
      tx_sw_q <= tx_sw_d;
    end
  end

  for (genvar g = 0; g < `LSR_LANES; g++) begin : g_lane
    always_comb begin
      tx_ila_d[g] = tx_sw_q;
      tx_ila_d[g].version = tx_cfg.version;
      tx_ila_d[g].subclass = tx_cfg.subclass;
      tx_ila_d[g].f = tx_cfg.f;
      tx_ila_d[g].k = tx_cfg.k;
      tx_ila_d[g].l = tx_cfg.l;
      tx_ila_d[g].lid = lane_identifier_q[g];
      tx_ila_d[g].scr = tx_cfg.scr;
      tx_ila_d[g].fchk = 8'h00;
      tx_ila_d[g].fchk = ila_sum(tx_ila_d[g]);
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        lane_identifier_q[g] <= `LSR_LID_W'(g);
      end else if (wr_go && sel_lid && req.lane == 3'(g)) begin
        lane_identifier_q[g] <= wd[`LSR_LID_W-1:0];
      end
    end

    // captured values are kept only on the receive side
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        rx_q[g] <= '0;
      end else if (ce && !mode_tx && ila_rx_valid[g]) begin
        rx_q[g] <= ila_rx[g];
      end
    end

    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        tx_ila_q[g] <= '0;
      end else if (ce) begin
        tx_ila_q[g] <= tx_ila_d[g];
      end
    end

    assign tx_ila[g] = tx_ila_q[g];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `LSR_ZERO;
      rvalid_q <= 1'b0;
    end else if (ce) begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        rdata_q <= rd_word;
      end
    end
  end

  assign rdata = rdata_q;
  assign rvalid = rvalid_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sysref_set_a: assert property (
    ce && subclass_one && sysref_evt |=> sysref_q
  ) else $error("sysref flag not set after capture");

  sysref_hold_a: assert property (
    sysref_q |=> sysref_q
  ) else $error("sysref flag dropped without reset");

  sync_follow_a: assert property (
    ce ##1 ce |=> rdata_q[`LSR_SYNC_BIT] == $past(link_sync, 2)
      || !$past(req.rd) || !$past(sel_sync)
  ) else $error("sync status does not follow link");

  sod_sticky_a: assert property (
    ce && lane_ev[0].sod && dbg_clr |=> sod_q[0] [*2] or
      (sod_q[0] ##1 !sod_q[0] && $past(dbg_clr))
  ) else $error("start of data lost on clearing read");

  soila_clear_a: assert property (
    ce && dbg_clr && !lane_ev[1].soila |=> !soila_q[1]
  ) else $error("sticky flag not cleared by read");

  soila_keep_a: assert property (
    soila_q[2] && !(ce && dbg_clr) |=> soila_q[2]
  ) else $error("sticky flag dropped without read");

  live_bits_a: assert property (
    ce && req.rd && sel_dbg |=>
      rdata_q[`LSR_DBG_CGS] == $past(lane_ev[0].cgs) &&
      rdata_q[`LSR_DBG_K28] == $past(lane_ev[0].k28)
  ) else $error("live lane bits not reported");

  lane_identifier_wr_a: assert property (
    wr_go && sel_lid && req.lane == 3'h3 |=>
      lane_identifier_q[3] == $past(wd[`LSR_LID_W-1:0])
  ) else $error("lane_identifier write not stored");

  rx_capture_a: assert property (
    ce && !mode_tx && ila_rx_valid[0] |=> rx_q[0] == $past(ila_rx[0])
  ) else $error("captured parameters not stored");

  tx_fchk_a: assert property (
    ce |=> tx_ila_q[4].fchk == ila_sum(tx_ila_q[4])
  ) else $error("transmit checksum not computed");

  tx_lid_a: assert property (
    ce |=> tx_ila_q[5].lid == $past(lane_identifier_q[5]) &&
      tx_ila_q[5].l == $past(tx_cfg.l)
  ) else $error("transmit lane fields not from configuration");

  sync_rsvd_a: assert property (
    rd_go && sel_sync |=> (rdata_q & ~`LSR_SYNC_MASK) == `LSR_ZERO
  ) else $error("reserved sync bits not zero");

  hide_cfg_a: assert property (
    rd_go && hide_cfg |=> rdata_q == `LSR_ZERO
  ) else $error("generated transmit register not hidden");

  rx_no_wr_a: assert property (
    ce && !mode_tx |=> tx_sw_q == $past(tx_sw_q)
  ) else $error("transmit fields written in receive mode");

  sod_set_a: assert property (
    ce && lane_ev[6].sod |=> sod_q[6]
  ) else $error("start of data not flagged");

  soila_set_a: assert property (
    ce && lane_ev[3].soila |=> soila_q[3]
  ) else $error("start of alignment not flagged");

  cgs_live_a: assert property (
    ce && req.rd && sel_dbg |=>
      rdata_q[7*`LSR_DBG_W + `LSR_DBG_CGS] == $past(lane_ev[7].cgs)
  ) else $error("lane 7 code group sync not reported");

  rx_hold_a: assert property (
    ce && mode_tx |=> rx_q[6] == $past(rx_q[6])
  ) else $error("captured parameters changed in transmit mode");

  tx_m_wr_a: assert property (
    sw_wr && req.idx == `LSR_IDX_CFG4 |=>
      tx_sw_q.m == $past(wd[`LSR_M_LSB +: 8])
  ) else $error("converter count write not stored");

  scr_tx_a: assert property (
    ce |=> tx_ila_q[2].scr == $past(tx_cfg.scr)
  ) else $error("transmit scrambling flag not from configuration");

  sysref_cov: cover property (ce && subclass_one && sysref_evt ##1 sysref_q);
  clear_cov: cover property (soila_q[0] && dbg_clr ##1 !soila_q[0]);
  capture_cov: cover property (ce && !mode_tx && ila_rx_valid[7]);
  tx_write_cov: cover property (sw_wr && req.idx == `LSR_IDX_CFG4);
  sticky_race_cov: cover property (ce && lane_ev[0].sod && dbg_clr);

endmodule
`default_nettype wire
